// File: testbench/mpd_core_model.sv
// Behavioural model of the processor core that feeds the stream data port.
// Assumes the decoder samples streamWrite and streamByte on the rising edge of ref_clk.
`timescale 1ns/1ns
`default_nettype none

module mpd_core_model (
  input  wire logic          ref_clk,          // System clock
  input  wire logic          rst_n,            // Async reset, active low
  input  wire logic          go,               // Serve requests when high
  input  wire logic          strayWrite,       // Write without a pending request
  input  wire logic          frameRequestFlag, // Decoder wants frame data
  output logic               streamWrite,      // Byte write strobe
  output mpd_pkg::mpd_byte_t streamByte,       // Written byte
  output logic [15:0]        sent              // Bytes delivered while serving
);
  import mpd_pkg::*;

  // ----------------------------------------
  // Stream content
  // ----------------------------------------
  // Even frames carry a version one header, odd frames a version two header;
  // the third frame has a broken sync and a reserved rate index
  function automatic mpd_byte_t frameByte(input logic [15:0] n);
    logic [15:0] p;
    logic [15:0] q;
    p = n % 16'h01a1;
    q = n / 16'h01a1;
    case (p)
      16'h0000: frameByte = (q == 16'h0002) ? 8'h7f : 8'hff;  // Sync top bits
      16'h0001: frameByte = q[0] ? 8'hf2 : 8'hfa;  // Sync, version, layer
      16'h0002: frameByte = (q == 16'h0002) ? 8'h9c : (q[0] ? 8'h98 : 8'h94);  // Rate index 10, 01 or 11
      16'h0003: frameByte = 8'h00;
      default:  frameByte = 8'ha5;                 // Body filler
    endcase
  endfunction

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // Decides after each edge, holds the strobe for whole cycles
  initial
  begin
    streamWrite = 1'b0;
    streamByte  = 8'h00;
    sent        = 16'h0000;
    forever
    begin
      @(posedge ref_clk);
      if (streamWrite && go)
      begin
        sent = sent + 16'h0001;                                    // Each write acknowledges
      end
      #2;
      streamWrite = rst_n && (strayWrite || (go && frameRequestFlag)); // Feed until request drops
      streamByte  = streamWrite ? frameByte(sent) : ~streamByte;     // Idle bus never repeats data
    end
  end
endmodule

`default_nettype wire

// File: testbench/mpd_testbench.sv
// Self-checking bench for the stream decoder input handshake.
// Assumes mpd_pkg and the core model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import mpd_pkg::*;

  logic              ref_clk;
  logic              rst_n;
  logic              decoderEnable;
  logic              irqEnable;
  mpd_div_t          clockDivisor;
  logic              statusRead;
  logic              go;
  logic              strayWrite;
  logic              streamWrite;
  mpd_byte_t         streamByte;
  logic [15:0]       sent;
  logic              dataRequestFlag;
  logic              frameRequestFlag;
  logic              byteRequestToggle;
  logic              irqRequest;
  logic              streamVersionBit;
  logic [1:0]        sampleRateCode;
  logic              rateSupported;
  logic              syncError;
  mpd_pcm_t          pcmSample;
  logic              pcmValid;
  logic              earlyPcm;
  int                error_cnt;
  int                n_checks;
  int                cyc;
  int                i;
  int                n;

  mpd_stream_decoder DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .decoderEnable(decoderEnable), .irqEnable(irqEnable),
    .clockDivisor(clockDivisor), .streamWrite(streamWrite), .streamByte(streamByte),
    .statusRead(statusRead), .dataRequestFlag(dataRequestFlag), .frameRequestFlag(frameRequestFlag),
    .byteRequestToggle(byteRequestToggle), .irqRequest(irqRequest), .streamVersionBit(streamVersionBit),
    .sampleRateCode(sampleRateCode), .rateSupported(rateSupported), .syncError(syncError),
    .pcmSample(pcmSample), .pcmValid(pcmValid)
  );

  mpd_core_model core (
    .ref_clk(ref_clk), .rst_n(rst_n), .go(go), .strayWrite(strayWrite),
    .frameRequestFlag(frameRequestFlag), .streamWrite(streamWrite), .streamByte(streamByte), .sent(sent)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One cycle, then the bench's fixed drive delay
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // Cycles until the next sample strobe
  task automatic wait_pcm(output int cnt);
    cnt = 0;
    do
    begin
      tick();
      cnt++;
    end while (pcmValid !== 1'b1 && cnt < 200);
  endtask

  task automatic report_and_stop();
    $display("TB: checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Clock, hang guard and early-sample watch
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    cyc      = 0;
    earlyPcm = 1'b0;
    forever
    begin
      tick();
      cyc++;
      if (pcmValid === 1'b1 && sent < 16'h01a1)
        earlyPcm = 1'b1;
      if (cyc == 40000)
      begin
        error_cnt++;
        $display("CHECK FAILED %0t timeout", $time);
        report_and_stop();
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    rst_n = 1'b0;
    decoderEnable = 1'b0;
    irqEnable = 1'b0;
    clockDivisor = 5'h1f;
    statusRead = 1'b0;
    go = 1'b0;
    strayWrite = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    tick();
    chk(!dataRequestFlag && !frameRequestFlag && !byteRequestToggle && !irqRequest, "reset levels");
    strayWrite = 1'b1;
    tick();
    strayWrite = 1'b0;
    repeat (2) tick();
    chk(byteRequestToggle === 1'b0, "write while disabled toggled");
    decoderEnable = 1'b1;
    tick();
    chk(frameRequestFlag === 1'b1 && dataRequestFlag === 1'b1, "no request after enable");
    chk(irqRequest === 1'b0, "interrupt while disabled");
    irqEnable = 1'b1;
    tick();
    chk(irqRequest === 1'b1, "interrupt missing");
    statusRead = 1'b1;
    tick();
    statusRead = 1'b0;
    chk(!dataRequestFlag && frameRequestFlag && !irqRequest, "status read effect");
    go = 1'b1;
    for (i = 0; i < 3000 && frameRequestFlag === 1'b1; i++) tick();
    chk(frameRequestFlag === 1'b0 && sent >= 16'h0400 && sent < 16'h0450, "first fill size");
    chk(byteRequestToggle === sent[0] && dataRequestFlag === 1'b0, "toggle count");
    chk(streamVersionBit && sampleRateCode === 2'b01 && rateSupported && !syncError, "v1 header");
    chk(earlyPcm === 1'b0, "sample before full frame");
    wait_pcm(n);
    chk(pcmSample === 16'ha500, "sample value");
    clockDivisor = 5'h03; // Faster decoder clock once the version is known
    wait_pcm(n);
    wait_pcm(n);
    wait_pcm(n);
    chk(n == 4, "divider spacing");
    for (i = 0; i < 3000 && frameRequestFlag !== 1'b1; i++) tick();
    chk(frameRequestFlag && dataRequestFlag && irqRequest, "request not renewed");
    for (i = 0; i < 3000 && streamVersionBit !== 1'b0; i++) tick();
    tick();
    chk(!streamVersionBit && sampleRateCode === 2'b10 && rateSupported && !syncError, "v2 header");
    for (i = 0; i < 3000 && streamVersionBit !== 1'b1; i++) tick();
    tick();
    chk(syncError && !rateSupported && sampleRateCode === 2'b11, "bad header not flagged");
    decoderEnable = 1'b0;
    go = 1'b0;
    tick();
    chk(frameRequestFlag === 1'b0, "request after disable");
    report_and_stop();
  end
endmodule

`default_nettype wire

// File: verilog/mpd_defines.svh
// Constants of the compressed stream input and decoder core.
// Assumes inclusion by bare name from the package and the decoder.
`ifndef MPD_DEFINES_SVH
`define MPD_DEFINES_SVH

// ----------------------------------------
// Input buffer
// ----------------------------------------
`define MPD_BUF_BYTES   11'd1024
`define MPD_PTR_W       10
`define MPD_CNT_W       11

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define MPD_FRAME_BYTES 11'd417
`define MPD_HDR_BYTES   11'd4
`define MPD_SYNC_MSB    31
`define MPD_SYNC_LSB    21
`define MPD_VER_POS     19
`define MPD_FS_MSB      11
`define MPD_FS_LSB      10
`define MPD_FS_RSVD     2'b11

// ----------------------------------------
// Decoder clock divider
// ----------------------------------------
`define MPD_DIV_W       5

`endif

// File: verilog/mpd_pkg.sv
// Types shared by the stream decoder.
// Assumes mpd_defines.svh is on the include path.
`include "mpd_defines.svh"
`default_nettype none

package mpd_pkg;
  typedef logic [7:0]  mpd_byte_t;
  typedef logic [15:0] mpd_pcm_t;
  typedef logic [`MPD_DIV_W-1:0] mpd_div_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HDR, ST_BODY} mpd_state_t;
endpackage

`default_nettype wire

// File: verilog/mpd_stream_decoder.sv
// Compressed stream input, request handshake and decoder core.
// Assumes the core drives write and read strobes synchronous to ref_clk.
//
// What this block does
// - No frame decode starts before the whole frame sits in the input buffer.
// - When input is needed the data and frame request flags set and the byte toggle runs.
// - The data request flag drives the interrupt request when the interrupt is enabled.
// - The frame request flag stays high while data is wanted, drops when full, rises again when needed.
// - The byte request toggle flips on every byte the buffer accepts (decoder enabled, buffer not full).
// - The first request after enable asks for 1024 bytes and the core delivers them.
// - Reading the status register clears the data request flag.
// - The decoder clock is ref_clk divided by a factor from a five-bit divisor field.
// - Version one streams at 48, 44.1 and 32 kHz are accepted.
// - Version two streams at 24, 22.05 and 16 kHz are accepted as well.
// - Input bytes become PCM samples in hardware, paced by the decoder clock.
// - The version bit reads 1 for version one and 0 for version two streams.
`timescale 1ns/1ns
`default_nettype none
`include "mpd_defines.svh"

module mpd_stream_decoder (
  input  wire logic              ref_clk,           // System clock, 25 MHz
  input  wire logic              rst_n,             // Async reset, active low
  input  wire logic              decoderEnable,     // Decoder enable bit
  input  wire logic              irqEnable,         // Request interrupt enable
  input  wire mpd_pkg::mpd_div_t clockDivisor,      // Decoder clock divisor
  input  wire logic              streamWrite,       // Write to stream data port
  input  wire mpd_pkg::mpd_byte_t streamByte,       // Written stream byte
  input  wire logic              statusRead,        // Read of status register
  output logic                   dataRequestFlag,   // Sticky data request
  output logic                   frameRequestFlag,  // Frame data wanted
  output logic                   byteRequestToggle, // Flips per byte accepted
  output logic                   irqRequest,        // Interrupt to core
  output logic                   streamVersionBit,  // 1 version one, 0 two
  output logic [1:0]             sampleRateCode,    // Header rate index
  output logic                   rateSupported,     // Rate index is legal
  output logic                   syncError,         // Last header lacked sync
  output mpd_pkg::mpd_pcm_t      pcmSample,         // Decoded sample
  output logic                   pcmValid           // Sample strobe
);
  import mpd_pkg::*;

  // ----------------------------------------
  // Decoder clock enable
  // ----------------------------------------
  mpd_div_t divCnt;
  mpd_div_t next_divCnt;
  logic     decEn;

  // Divide ref_clk by divisor plus one into a one-cycle enable
  always_comb
  begin
    decEn       = decoderEnable && (divCnt == clockDivisor);
    next_divCnt = (decEn || !decoderEnable) ? '0 : divCnt + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      divCnt <= '0;
    else
      divCnt <= next_divCnt;
  end

  // ----------------------------------------
  // Input buffer
  // ----------------------------------------
  mpd_byte_t             bufMem [0:`MPD_BUF_BYTES-1];
  logic [`MPD_PTR_W-1:0] wrPtr;
  logic [`MPD_PTR_W-1:0] rdPtr;
  logic [`MPD_CNT_W-1:0] fill;
  logic [`MPD_PTR_W-1:0] next_wrPtr;
  logic [`MPD_PTR_W-1:0] next_rdPtr;
  logic [`MPD_CNT_W-1:0] next_fill;
  logic                  wrOk;
  logic                  rdOk;
  mpd_byte_t             rdByte;
  mpd_state_t            state;

  // Each accepted write acknowledges the request; a full buffer drops it
  always_comb
  begin
    wrOk   = streamWrite && decoderEnable && (fill != `MPD_BUF_BYTES);
    rdOk   = decEn && (state == ST_HDR || state == ST_BODY);
    rdByte = bufMem[rdPtr];
    if (!decoderEnable)
    begin
      next_wrPtr = '0; // Empty buffer so the first request is a full fill
      next_rdPtr = '0;
      next_fill  = '0;
    end
    else
    begin
      next_wrPtr = wrPtr + `MPD_PTR_W'(wrOk);
      next_rdPtr = rdPtr + `MPD_PTR_W'(rdOk);
      next_fill  = fill + `MPD_CNT_W'(wrOk) - `MPD_CNT_W'(rdOk);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fill  <= next_fill;
    end
  end

  // Buffer storage, written by accepted stream bytes
  always_ff @(posedge ref_clk)
  begin
    if (wrOk)
      bufMem[wrPtr] <= streamByte;
  end

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  logic next_frameReq;
  logic next_dataReq;
  logic next_toggle;
  logic setReq;

  // Frame request holds until full and returns once a frame fits again
  always_comb
  begin
    if (!decoderEnable || next_fill == `MPD_BUF_BYTES)
      next_frameReq = 1'b0;
    else if ((`MPD_BUF_BYTES - next_fill) >= `MPD_FRAME_BYTES)
      next_frameReq = 1'b1;
    else
      next_frameReq = frameRequestFlag;
    setReq       = next_frameReq && !frameRequestFlag;
    // A new request wins over a clearing status read
    next_dataReq = setReq || (dataRequestFlag && !statusRead);
    next_toggle  = byteRequestToggle ^ wrOk;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameRequestFlag  <= 1'b0;
      dataRequestFlag   <= 1'b0;
      byteRequestToggle <= 1'b0;
    end
    else
    begin
      frameRequestFlag  <= next_frameReq;
      dataRequestFlag   <= next_dataReq;
      byteRequestToggle <= next_toggle;
    end
  end

  // Interrupt gated by its enable
  assign irqRequest = dataRequestFlag && irqEnable;

  // ----------------------------------------
  // Frame decoder
  // ----------------------------------------
  mpd_state_t            next_state;
  logic [`MPD_CNT_W-1:0] byteIdx;
  logic [`MPD_CNT_W-1:0] next_byteIdx;
  logic [31:0]           hdr;
  logic [31:0]           next_hdr;
  logic                  next_ver;
  logic [1:0]            next_fs;
  logic                  next_syncErr;
  mpd_pcm_t              next_pcm;
  logic                  next_pcmValid;
  logic                  hdrDone;

  // Wait for a whole frame, parse its header, then emit samples
  always_comb
  begin
    next_state    = state;
    next_byteIdx  = byteIdx;
    next_hdr      = hdr;
    next_ver      = streamVersionBit;
    next_fs       = sampleRateCode;
    next_syncErr  = syncError;
    next_pcm      = pcmSample;
    next_pcmValid = 1'b0;
    hdrDone       = 1'b0;
    unique case (state)
      ST_IDLE:
        if (decoderEnable)
          next_state = ST_WAIT;
      ST_WAIT:
        if (fill >= `MPD_FRAME_BYTES)
        begin
          next_state   = ST_HDR;
          next_byteIdx = '0;
        end
      ST_HDR:
        if (decEn)
        begin
          next_hdr     = {hdr[23:0], rdByte};
          next_byteIdx = byteIdx + 1'b1;
          if (byteIdx == `MPD_HDR_BYTES - 1'b1)
          begin
            hdrDone      = 1'b1;
            next_ver     = next_hdr[`MPD_VER_POS];
            next_fs      = next_hdr[`MPD_FS_MSB:`MPD_FS_LSB];
            next_syncErr = ~&next_hdr[`MPD_SYNC_MSB:`MPD_SYNC_LSB];
            next_state   = ST_BODY;
          end
        end
      ST_BODY:
        if (decEn)
        begin
          next_pcm      = {rdByte, 8'h00};
          next_pcmValid = 1'b1;
          next_byteIdx  = byteIdx + 1'b1;
          if (byteIdx == `MPD_FRAME_BYTES - 1'b1)
            next_state = ST_WAIT;
        end
    endcase
    if (!decoderEnable)
      next_state = ST_IDLE;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state            <= ST_IDLE;
      byteIdx          <= '0;
      hdr              <= '0;
      streamVersionBit <= 1'b0;
      sampleRateCode   <= 2'h0;
      syncError        <= 1'b0;
      pcmSample        <= 16'h0000;
      pcmValid         <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      byteIdx          <= next_byteIdx;
      hdr              <= next_hdr;
      streamVersionBit <= next_ver;
      sampleRateCode   <= next_fs;
      syncError        <= next_syncErr;
      pcmSample        <= next_pcm;
      pcmValid         <= next_pcmValid;
    end
  end

  // Both stream versions share the same three legal rate indices
  assign rateSupported = (sampleRateCode != `MPD_FS_RSVD);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence sNewRequest;
    !frameRequestFlag ##1 frameRequestFlag;
  endsequence

  sequence sEnableRise;
    !decoderEnable ##1 decoderEnable;
  endsequence

  a_frame_whole: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_WAIT && next_state == ST_HDR) |-> fill >= `MPD_FRAME_BYTES)
    else $error("frame decode started before whole frame buffered");

  a_request_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sNewRequest |-> dataRequestFlag)
    else $error("new frame request did not set data request");

  a_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dataRequestFlag) && irqEnable |-> irqRequest)
    else $error("enabled data request raised no interrupt");

  a_full_drops: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fill == `MPD_BUF_BYTES |-> !frameRequestFlag)
    else $error("frame request high with full buffer");

  a_toggle_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrOk |=> byteRequestToggle != $past(byteRequestToggle))
    else $error("byte toggle did not flip on write");

  a_first_fill: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sEnableRise |-> fill == 11'd0 ##1 frameRequestFlag)
    else $error("first request after enable is not a full fill");

  a_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    statusRead && !setReq |=> !dataRequestFlag)
    else $error("status read did not clear data request");

  a_read_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    statusRead && !wrOk && !rdOk && decoderEnable && $past(decoderEnable)
      |=> $stable(frameRequestFlag) && $stable(byteRequestToggle))
    else $error("status read disturbed frame request or toggle");

  a_div_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    decEn && clockDivisor != 5'h00 && $stable(clockDivisor) |=> !decEn)
    else $error("decoder enable repeated inside divide period");

  a_version_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hdrDone |=> streamVersionBit == hdr[`MPD_VER_POS] && state == ST_BODY)
    else $error("version bit not taken from header");
endmodule
`default_nettype wire
